// ---- hdl/quad_regulator_enable_control.sv ----
// enable, mode, setpoint and power-good control for four regulators
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
module quad_regulator_enable_control #(
  parameter int PG_DELAY = regctl_pkg::PG_DELAY_CYCLES,
  parameter int SS_DELAY = regctl_pkg::SOFT_START_CYCLES
) (
  input  wire logic                          clk_i,
  input  wire logic                          reset_i,
  input  wire logic                          supply_undervoltage_lock_i,
  input  wire logic [7:0]                    addr_i,
  input  wire logic [7:0]                    wdata_i,
  input  wire logic                          wr_i,
  input  wire logic                          rd_i,
  output logic      [7:0]                    rdata_o,
  input  wire logic                          reg_a_high_enable_pin_n_i,
  input  wire logic                          reg_a_low_enable_pin_i,
  input  wire logic                          reg_a_high_good_i,
  output logic      [regctl_pkg::NUM_REGS-1:0] reg_enable_o,
  output logic      [regctl_pkg::NUM_REGS-1:0] soft_start_o,
  output logic      [7:0]                    reg_mode_o,
  output logic      [3:0]                    reg_a_high_set_o,
  output logic      [3:0]                    reg_a_low_set_o,
  output logic      [6:0]                    reg_b_high_set_o,
  output logic      [6:0]                    reg_b_low_set_o,
  output logic                               power_good_reset_out_o,
  output logic                               power_good_reset_out_oe_o
);
  import regctl_pkg::*;

  // =====================================================
  // input synchronisation
  logic       uv_sync;
  logic [2:0] pin_sync;
  logic       a_high_pin_on;
  logic       a_low_pin_on;
  logic       a_high_good;

  sync2 #(.WIDTH(3)) u_pin_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .async_i ({reg_a_high_good_i, reg_a_low_enable_pin_i, ~reg_a_high_enable_pin_n_i}),
    .sync_o  (pin_sync)
  );

  sync2 #(.WIDTH(1)) u_uv_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .async_i (supply_undervoltage_lock_i),
    .sync_o  (uv_sync)
  );

  assign a_high_pin_on = pin_sync[0];
  assign a_low_pin_on  = pin_sync[1];
  assign a_high_good   = pin_sync[2];

  // =====================================================
  // control registers
  logic [3:0] host_enable;
  logic [7:0] mode;
  logic [3:0] a_high_set;
  logic [3:0] a_low_set;
  logic [6:0] b_high_set;
  logic [6:0] b_low_set;
  logic       clear_regs;

  assign clear_regs = reset_i | uv_sync;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_addr);
    hit = (a == ref_addr);
  endfunction

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      host_enable <= RST_ENABLE;
      mode        <= RST_MODE;
      a_high_set  <= RST_A_SET;
      a_low_set   <= RST_A_SET;
      b_high_set  <= RST_B_SET;
      b_low_set   <= RST_B_SET;
    end else if (uv_sync) begin
      host_enable <= RST_ENABLE;
      mode        <= RST_MODE;
      a_high_set  <= RST_A_SET;
      a_low_set   <= RST_A_SET;
      b_high_set  <= RST_B_SET;
      b_low_set   <= RST_B_SET;
    end else if (wr_i) begin
      // each write lands at once, no disable needed
      if (hit(addr_i, ADDR_ENABLE)) begin
        host_enable <= wdata_i[3:0];
      end else if (hit(addr_i, ADDR_MODE)) begin
        mode <= wdata_i;
      end else if (hit(addr_i, ADDR_A_HIGH_SET)) begin
        a_high_set <= wdata_i[3:0];
      end else if (hit(addr_i, ADDR_A_LOW_SET)) begin
        a_low_set <= wdata_i[3:0];
      end else if (hit(addr_i, ADDR_B_HIGH_SET)) begin
        b_high_set <= wdata_i[6:0];
      end else if (hit(addr_i, ADDR_B_LOW_SET)) begin
        b_low_set <= wdata_i[6:0];
      end
    end
  end

  // =====================================================
  // enable combination
  logic [3:0] next_enable;

  always_comb begin
    next_enable             = host_enable;
    next_enable[IDX_A_HIGH] = host_enable[IDX_A_HIGH] | a_high_pin_on;
    next_enable[IDX_A_LOW]  = host_enable[IDX_A_LOW] | a_low_pin_on;
    next_enable[IDX_B_HIGH] = host_enable[IDX_B_HIGH];
    next_enable[IDX_B_LOW]  = host_enable[IDX_B_LOW];
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_enable_o     <= '0;
      reg_mode_o       <= RST_MODE;
      reg_a_high_set_o <= RST_A_SET;
      reg_a_low_set_o  <= RST_A_SET;
      reg_b_high_set_o <= RST_B_SET;
      reg_b_low_set_o  <= RST_B_SET;
    end else begin
      reg_enable_o     <= next_enable;
      reg_mode_o       <= mode;
      reg_a_high_set_o <= a_high_set;
      reg_a_low_set_o  <= a_low_set;
      reg_b_high_set_o <= b_high_set;
      reg_b_low_set_o  <= b_low_set;
    end
  end

  // =====================================================
  // soft-start timers, one per regulator
  localparam int SS_W = $clog2(SS_DELAY + 1);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_ss
      logic [SS_W-1:0] ss_count;
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          ss_count <= '0;
        end else if (!reg_enable_o[gi]) begin
          ss_count <= '0;
        end else if (next_enable[gi] && ss_count < SS_W'(SS_DELAY)) begin
          ss_count <= ss_count + 1'b1;
        end
      end
      assign soft_start_o[gi] = reg_enable_o[gi] && (ss_count < SS_W'(SS_DELAY));
    end
  endgenerate

  // =====================================================
  // power-good delay
  localparam int PG_W = $clog2(PG_DELAY + 1);
  logic [PG_W-1:0] pg_count;
  logic            pg_released;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pg_count    <= '0;
      pg_released <= 1'b0;
    end else if (!a_high_good) begin
      pg_count    <= '0;
      pg_released <= 1'b0;
    end else if (pg_count < PG_W'(PG_DELAY - 1)) begin
      pg_count <= pg_count + 1'b1;
    end else begin
      pg_released <= 1'b1;
    end
  end

  assign power_good_reset_out_o    = 1'b0;
  assign power_good_reset_out_oe_o = ~pg_released;

  // =====================================================
  // read port: status only, settings are write-only
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i && hit(addr_i, ADDR_STATUS)) begin
      rdata_o <= {2'h0, pg_released, a_high_good, reg_enable_o};
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // =====================================================
  // checks
  sequence s_good_run;
    a_high_good [*8];
  endsequence

  chk_pin_enable_or: assert property (@(posedge clk_i) disable iff (reset_i)
    a_high_pin_on |=> reg_enable_o[IDX_A_HIGH])
    else $error("high pin enable not seen on type-A output");

  chk_pin_low_or: assert property (@(posedge clk_i) disable iff (reset_i)
    a_low_pin_on |=> reg_enable_o[IDX_A_LOW])
    else $error("low pin enable not seen on type-A output");

  chk_b_host_only: assert property (@(posedge clk_i) disable iff (reset_i)
    reg_enable_o[IDX_B_HIGH] |-> $past(host_enable[IDX_B_HIGH]))
    else $error("type-B enabled without host bit");

  chk_uv_defaults: assert property (@(posedge clk_i) disable iff (reset_i)
    uv_sync |=> (host_enable == RST_ENABLE && a_high_set == RST_A_SET && mode == RST_MODE))
    else $error("undervoltage did not restore defaults");

  chk_write_live: assert property (@(posedge clk_i) disable iff (clear_regs)
    (wr_i && hit(addr_i, ADDR_A_HIGH_SET)) |=> ##1 (reg_a_high_set_o == $past(wdata_i[3:0], 2)))
    else $error("setpoint write not applied");

  chk_pg_low: assert property (@(posedge clk_i) disable iff (reset_i)
    !a_high_good |=> power_good_reset_out_oe_o)
    else $error("power-good not pulled low");

  chk_pg_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    ($rose(a_high_good) ##0 s_good_run) |-> power_good_reset_out_oe_o)
    else $error("power-good released early");

  chk_pg_release: assert property (@(posedge clk_i) disable iff (reset_i)
    (pg_count == PG_W'(PG_DELAY - 1) && a_high_good) |=> !power_good_reset_out_oe_o)
    else $error("power-good not released at delay end");

  chk_ss_start: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(reg_enable_o[0]) |-> soft_start_o[0])
    else $error("soft-start missing on enable");
endmodule
`default_nettype wire

// ---- shared/regctl_pkg.sv ----
// shared constants for the quad regulator enable control
package regctl_pkg;
  // =====================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_ENABLE     = 8'h00;
  localparam logic [7:0] ADDR_MODE       = 8'h04;
  localparam logic [7:0] ADDR_A_HIGH_SET = 8'h08;
  localparam logic [7:0] ADDR_A_LOW_SET  = 8'h0C;
  localparam logic [7:0] ADDR_B_HIGH_SET = 8'h10;
  localparam logic [7:0] ADDR_B_LOW_SET  = 8'h14;
  localparam logic [7:0] ADDR_STATUS     = 8'h18;
  // =====================================================
  // field layouts
  localparam int NUM_REGS     = 4;
  localparam int A_SET_W      = 4;
  localparam int B_SET_W      = 7;
  localparam int MODE_W       = 2;
  localparam int IDX_A_HIGH   = 0;
  localparam int IDX_A_LOW    = 1;
  localparam int IDX_B_HIGH   = 2;
  localparam int IDX_B_LOW    = 3;
  // =====================================================
  // operating modes
  typedef enum logic [1:0] {
    MODE_PULSE_SKIP = 2'h0,
    MODE_AUTO_HYST  = 2'h1,
    MODE_FORCED_HYST = 2'h2,
    MODE_LINEAR     = 2'h3
  } op_mode_t;
  // =====================================================
  // reset values
  localparam logic [3:0] RST_ENABLE = 4'h0;
  localparam logic [7:0] RST_MODE   = 8'h00;
  localparam logic [3:0] RST_A_SET  = 4'hF;
  localparam logic [6:0] RST_B_SET  = 7'h00;
  // =====================================================
  // timing
  localparam int CLK_HZ           = 100_000_000;
  localparam int PG_DELAY_MS      = 230;
  localparam int PG_DELAY_CYCLES  = CLK_HZ / 1000 * PG_DELAY_MS;
  localparam int SOFT_START_US    = 500;
  localparam int SOFT_START_CYCLES = CLK_HZ / 1_000_000 * SOFT_START_US;
endpackage

// ---- hdl/sync2.sv ----
// two flip-flop synchroniser, parameterised width
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule
`default_nettype wire

// ---- sim/host_model.sv ----
// register bus host model for the regulator control bench
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output var  logic [7:0] addr_o,
  output var  logic [7:0] wdata_o,
  output var  logic       wr_o,
  output var  logic       rd_o
);
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // one-cycle write, any time after start
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

// ---- sim/quad_regulator_enable_control_bench.sv ----
// self-checking bench for the quad regulator enable control
`timescale 1ns/10ps
`default_nettype none
module quad_regulator_enable_control_bench;
  import regctl_pkg::*;
  // =====================================================
  // signals
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic [3:0] en;
    logic [7:0] mode;
    logic [3:0] ah;
    logic [3:0] al;
    logic [6:0] bh;
    logic [6:0] bl;
  } row_t;
  localparam logic [33:0] DEF = {4'h0, 8'h00, 4'hF, 4'hF, 7'h00, 7'h00};
  logic       clk_i;
  logic       reset_i;
  logic       uv;
  logic       pin_n;
  logic       pin;
  logic       good;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic [3:0] en;
  logic [3:0] ss;
  logic [7:0] mode;
  logic [3:0] ah;
  logic [3:0] al;
  logic [6:0] bh;
  logic [6:0] bl;
  logic       pg;
  logic       oe;
  logic [7:0] d;
  int         mismatches = 0;
  int         tests_run = 0;
  wire logic [33:0] st = {en, mode, ah, al, bh, bl};
  row_t rows [8] = '{
    '{8'h08, 8'h03, 4'h3, 8'h00, 4'h3, 4'hF, 7'h00, 7'h00},
    '{8'h0C, 8'h00, 4'h3, 8'h00, 4'h3, 4'h0, 7'h00, 7'h00},
    '{8'h10, 8'h7F, 4'h3, 8'h00, 4'h3, 4'h0, 7'h7F, 7'h00},
    '{8'h14, 8'h01, 4'h3, 8'h00, 4'h3, 4'h0, 7'h7F, 7'h01},
    '{8'h04, 8'hE4, 4'h3, 8'hE4, 4'h3, 4'h0, 7'h7F, 7'h01},
    '{8'h00, 8'h0C, 4'hF, 8'hE4, 4'h3, 4'h0, 7'h7F, 7'h01},
    '{8'h1C, 8'hFF, 4'hF, 8'hE4, 4'h3, 4'h0, 7'h7F, 7'h01},
    '{8'h18, 8'hFF, 4'hF, 8'hE4, 4'h3, 4'h0, 7'h7F, 7'h01}
  };
  // =====================================================
  // design and host
  quad_regulator_enable_control #(.PG_DELAY(20), .SS_DELAY(10)) DUT (
    .clk_i(clk_i), .reset_i(reset_i), .supply_undervoltage_lock_i(uv),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .reg_a_high_enable_pin_n_i(pin_n), .reg_a_low_enable_pin_i(pin),
    .reg_a_high_good_i(good), .reg_enable_o(en), .soft_start_o(ss),
    .reg_mode_o(mode), .reg_a_high_set_o(ah), .reg_a_low_set_o(al),
    .reg_b_high_set_o(bh), .reg_b_low_set_o(bl),
    .power_good_reset_out_o(pg), .power_good_reset_out_oe_o(oe)
  );
  host_model host (
    .clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd)
  );
  // =====================================================
  // helpers
  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // =====================================================
  // stimulus
  initial clk_i = 1'b0;
  always #5 clk_i = ~clk_i;
  initial begin
    #20000;
    mismatches++;
    print_verdict();
  end
  initial begin
    reset_i = 1'b1;
    uv = 1'b0;
    pin_n = 1'b1;
    pin = 1'b0;
    good = 1'b0;
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    #1;
    check(st, DEF);
    check({rdata, oe, pg}, 34'h2);
    @(posedge clk_i);
    pin_n <= 1'b0;
    pin <= 1'b1;
    tick(2);
    check(en, 34'h0);
    tick(1);
    check(st, {4'h3, DEF[29:0]});
    check(ss, 34'h3);
    tick(15);
    check(ss, 34'h0);
    foreach (rows[i]) begin
      host.wr(rows[i].addr, rows[i].data);
      tick(2);
      check(st, rows[i][33:0]);
    end
    tick(15);
    host.wr(ADDR_MODE, 8'h1B);
    tick(2);
    check(ss, 34'h0);
    @(posedge clk_i);
    pin_n <= 1'b1;
    pin <= 1'b0;
    tick(3);
    check(en, 34'hC);
    host.wr(ADDR_ENABLE, 8'h01);
    tick(2);
    check(en, 34'h1);
    host.rd(ADDR_ENABLE, d);
    check(d, 34'h0);
    host.rd(ADDR_STATUS, d);
    check(d, 34'h01);
    @(posedge clk_i);
    good <= 1'b1;
    tick(15);
    check(oe, 34'h1);
    @(posedge clk_i);
    good <= 1'b0;
    tick(4);
    check(oe, 34'h1);
    @(posedge clk_i);
    good <= 1'b1;
    tick(15);
    check(oe, 34'h1);
    tick(15);
    check({oe, pg}, 34'h0);
    host.rd(ADDR_STATUS, d);
    check(d, 34'h31);
    @(posedge clk_i);
    good <= 1'b0;
    tick(3);
    check(oe, 34'h1);
    @(posedge clk_i);
    uv <= 1'b1;
    tick(4);
    check(st, DEF);
    host.wr(ADDR_A_HIGH_SET, 8'h05);
    tick(2);
    check(st, DEF);
    @(posedge clk_i);
    uv <= 1'b0;
    tick(3);
    check(st, DEF);
    print_verdict();
  end
endmodule
`default_nettype wire
